// File: peripheral_flags_pkg.sv
// constants shared by the peripheral interrupt flag block
// assumes a 32-bit apb slave with 8-bit wide registers in the low lane
package peripheral_flags_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FLAGS_OFS = 8'h0C;
  localparam logic [7:0] EVENT_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;
  localparam logic [7:0] PEND_OFS = 8'h18;

  // bit positions inside the flag register
  localparam int BIT_PSP = 7;
  localparam int BIT_ADC = 6;
  localparam int BIT_RX = 5;
  localparam int BIT_TX = 4;
  localparam int BIT_SSP = 3;
  localparam int BIT_CCP = 2;
  localparam int BIT_TIMER_TWO_COUNT = 1;
  localparam int BIT_TIMER_ONE_COUNT = 0;

  // bits that software may write in the flag register
  localparam logic [7:0] FLAGS_WR_MASK = 8'hCF;

  // control register fields
  localparam int CTRL_CCP_LSB = 0;
  localparam int CTRL_SSP_LSB = 2;
  localparam int CTRL_MM_BIT = 4;
  localparam int CTRL_W = 5;

  // values after reset
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] EVENT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  typedef enum logic [1:0] {
    CCP_OFF = 2'h0,
    CCP_CAPTURE = 2'h1,
    CCP_COMPARE = 2'h2,
    CCP_PWM = 2'h3
  } ccp_mode_t;

  typedef enum logic [1:0] {
    SSP_OFF = 2'h0,
    SSP_SPI = 2'h1,
    SSP_I2C_SLAVE = 2'h2,
    SSP_I2C_MASTER = 2'h3
  } ssp_mode_t;

endpackage : peripheral_flags_pkg

// File: flag_events_if.sv
// bundle between the flag register core and its event qualifier
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface flag_events_if;
  logic psp_access_done;
  logic adc_conv_done;
  logic rx_level;
  logic tx_level;
  logic ssp_byte_done;
  logic ssp_start_done;
  logic ssp_stop_done;
  logic ssp_restart_done;
  logic ssp_ack_done;
  logic bus_start_seen;
  logic bus_stop_seen;
  logic ssp_idle;
  logic ccp_capture;
  logic ccp_match;
  logic timer_two_count_match;
  logic timer_one_count_rollover;
  peripheral_flags_pkg::ccp_mode_t ccp_mode;
  peripheral_flags_pkg::ssp_mode_t ssp_mode;
  logic multi_master;
  logic [7:0] set_vec;
  logic [7:0] event_vec;

  modport core (
    output psp_access_done, adc_conv_done, rx_level, tx_level,
    output ssp_byte_done, ssp_start_done, ssp_stop_done,
    output ssp_restart_done, ssp_ack_done, bus_start_seen,
    output bus_stop_seen, ssp_idle, ccp_capture, ccp_match,
    output timer_two_count_match, timer_one_count_rollover, ccp_mode, ssp_mode, multi_master,
    input set_vec, event_vec
  );

  modport qualifier (
    input psp_access_done, adc_conv_done, rx_level, tx_level,
    input ssp_byte_done, ssp_start_done, ssp_stop_done,
    input ssp_restart_done, ssp_ack_done, bus_start_seen,
    input bus_stop_seen, ssp_idle, ccp_capture, ccp_match,
    input timer_two_count_match, timer_one_count_rollover, ccp_mode, ssp_mode, multi_master,
    output set_vec, event_vec
  );
endinterface : flag_events_if
`default_nettype wire

// File: flag_event_qualifier.sv
// turns raw peripheral pulses into per-bit set requests by mode
// assumes all peripheral inputs are on pclk, pulses one cycle wide
`timescale 1ns/1ps
`default_nettype none
module flag_event_qualifier #(
  parameter bit HAS_PSP = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  flag_events_if.qualifier ev
);

  logic rx_prev_ff;
  logic tx_prev_ff;
  logic nxt_rx_prev;
  logic nxt_tx_prev;
  logic ssp_set;
  logic ccp_set;
  logic i2c_mode;

  always_comb begin
    i2c_mode = (ev.ssp_mode == peripheral_flags_pkg::SSP_I2C_SLAVE) ||
               (ev.ssp_mode == peripheral_flags_pkg::SSP_I2C_MASTER);
    case (ev.ssp_mode)
      peripheral_flags_pkg::SSP_SPI: ssp_set = ev.ssp_byte_done;
      peripheral_flags_pkg::SSP_I2C_SLAVE: ssp_set = ev.ssp_byte_done;
      peripheral_flags_pkg::SSP_I2C_MASTER: begin
        ssp_set = ev.ssp_byte_done | ev.ssp_start_done |
                  ev.ssp_stop_done | ev.ssp_restart_done |
                  ev.ssp_ack_done;
      end
      default: ssp_set = 1'b0;
    endcase
    // bus conditions seen while the serial module sits idle
    if (i2c_mode && ev.multi_master && ev.ssp_idle &&
        (ev.bus_start_seen || ev.bus_stop_seen)) begin
      ssp_set = 1'b1;
    end
    case (ev.ccp_mode)
      peripheral_flags_pkg::CCP_CAPTURE: ccp_set = ev.ccp_capture;
      peripheral_flags_pkg::CCP_COMPARE: ccp_set = ev.ccp_match;
      peripheral_flags_pkg::CCP_PWM: ccp_set = 1'b0;
      default: ccp_set = 1'b0;
    endcase
  end

  // set requests ignore the mask; only bus start/stop needs the multi-master detect enable
  always_comb begin
    ev.set_vec = 8'h00;
    ev.set_vec[peripheral_flags_pkg::BIT_PSP] =
      HAS_PSP & ev.psp_access_done;
    ev.set_vec[peripheral_flags_pkg::BIT_ADC] = ev.adc_conv_done;
    ev.set_vec[peripheral_flags_pkg::BIT_SSP] = ssp_set;
    ev.set_vec[peripheral_flags_pkg::BIT_CCP] = ccp_set;
    ev.set_vec[peripheral_flags_pkg::BIT_TIMER_TWO_COUNT] = ev.timer_two_count_match;
    ev.set_vec[peripheral_flags_pkg::BIT_TIMER_ONE_COUNT] = ev.timer_one_count_rollover;
    nxt_rx_prev = ev.rx_level;
    nxt_tx_prev = ev.tx_level;
    ev.event_vec = ev.set_vec;
    ev.event_vec[peripheral_flags_pkg::BIT_RX] = ev.rx_level & ~rx_prev_ff;
    ev.event_vec[peripheral_flags_pkg::BIT_TX] = ev.tx_level & ~tx_prev_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_ff <= 1'b0;
      // an empty transmit buffer is the idle level, no false edge at start
      tx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= nxt_rx_prev;
      tx_prev_ff <= nxt_tx_prev;
    end
  end

endmodule : flag_event_qualifier
`default_nettype wire

// File: peripheral_interrupt_flags.sv
// peripheral interrupt flag register with apb access and event interrupt
// assumes peripheral inputs are on pclk; apb master follows apb4 rules
//
// Functional notes
// - each flag sets on its condition regardless of the mask; bus start/stop needs the multi-master enable
// - flag register at offset 0Ch, bits psp adc rx tx ssp ccp timer_two_count timer_one_count
// - bit 7 sets on a completed parallel port access, sticky
// - bit 6 sets when a conversion finishes, sticky
// - bit 5 read-only, high while receive buffer holds data
// - bit 4 read-only, high while transmit buffer is empty
// - spi and i2c slave set bit 3 per byte; software clears it
// - i2c master also sets bit 3 on finished start stop restart ack
// - multi-master: idle module sets bit 3 on bus start or stop
// - capture mode sets bit 2 on timer one capture, sticky
// - compare mode sets bit 2 on compare match, sticky
// - pwm mode never sets bit 2
// - bit 1 sets when timer two equals its period, sticky
// - bit 0 sets on timer one rollover, sticky
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_flags #(
  parameter int ADDR_W = 8,
  parameter bit HAS_PSP = 1'b1
) (
  // clock, reset and apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt line and flag view
  output logic irq,
  output logic [7:0] peripheral_request_flags_one,
  // peripheral pulses and buffer levels on pclk
  input wire logic psp_access_done,
  input wire logic adc_conv_done,
  input wire logic rx_buffer_full,
  input wire logic tx_buffer_empty,
  input wire logic ssp_byte_done,
  input wire logic ssp_start_done,
  input wire logic ssp_stop_done,
  input wire logic ssp_restart_done,
  input wire logic ssp_ack_done,
  input wire logic bus_start_seen,
  input wire logic bus_stop_seen,
  input wire logic ssp_idle,
  input wire logic ccp_capture,
  input wire logic ccp_match,
  input wire logic timer_two_count_match,
  input wire logic timer_one_count_rollover
);

  // register map, one byte in the low lane of each word:
  // 0x00 control: [1:0] capture/compare mode, [3:2] serial mode,
  //   [4] multi-master detect enable
  // 0x0C flags, 0x10 event status (a read clears it), 0x14 mask,
  // 0x18 pending = event status and mask, read only
  // register selected by the current address
  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_CTRL = 3'h1,
    REG_FLAGS = 3'h2,
    REG_EVENT = 3'h3,
    REG_MASK = 3'h4,
    REG_PEND = 3'h5
  } reg_sel_t;

  // map a byte address onto a register, anything else is unmapped
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    if (addr != ADDR_W'(a)) begin
      decode = REG_NONE;
    end else begin
      case (a)
        peripheral_flags_pkg::CTRL_OFS: decode = REG_CTRL;
        peripheral_flags_pkg::FLAGS_OFS: decode = REG_FLAGS;
        peripheral_flags_pkg::EVENT_OFS: decode = REG_EVENT;
        peripheral_flags_pkg::MASK_OFS: decode = REG_MASK;
        peripheral_flags_pkg::PEND_OFS: decode = REG_PEND;
        default: decode = REG_NONE;
      endcase
    end
  endfunction : decode

  // one strobe per register, shared by the write and read-clear paths
  function automatic logic reg_hit(input logic stb, input reg_sel_t s,
    input reg_sel_t want);
    reg_hit = stb && (s == want);
  endfunction : reg_hit

  flag_events_if ev ();

  // register state and next values
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [7:0] event_ff;
  logic [7:0] nxt_event;
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  logic [peripheral_flags_pkg::CTRL_W-1:0] ctrl_ff;
  logic [peripheral_flags_pkg::CTRL_W-1:0] nxt_ctrl;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic irq_ff;
  logic nxt_irq;
  logic [7:0] flags_view;
  logic setup;
  logic access;
  logic wr_lane;
  reg_sel_t sel;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [7:0] flag_keep;
  logic [7:0] pend_view;
  logic wr_flags;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_event;

  // apb phases and per-register strobes
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign sel = decode(paddr);
  assign wbyte = pwdata[7:0];
  assign wr_lane = access & pwrite & pstrb[0];
  assign wr_flags = reg_hit(wr_lane, sel, REG_FLAGS);
  assign wr_ctrl = reg_hit(wr_lane, sel, REG_CTRL);
  assign wr_mask = reg_hit(wr_lane, sel, REG_MASK);
  assign rd_event = reg_hit(access & ~pwrite, sel, REG_EVENT);

  // peripheral side of the qualifier bundle
  assign ev.psp_access_done = psp_access_done;
  assign ev.adc_conv_done = adc_conv_done;
  assign ev.rx_level = rx_buffer_full;
  assign ev.tx_level = tx_buffer_empty;
  assign ev.ssp_byte_done = ssp_byte_done;
  assign ev.ssp_start_done = ssp_start_done;
  assign ev.ssp_stop_done = ssp_stop_done;
  assign ev.ssp_restart_done = ssp_restart_done;
  assign ev.ssp_ack_done = ssp_ack_done;
  assign ev.bus_start_seen = bus_start_seen;
  assign ev.bus_stop_seen = bus_stop_seen;
  assign ev.ssp_idle = ssp_idle;
  assign ev.ccp_capture = ccp_capture;
  assign ev.ccp_match = ccp_match;
  assign ev.timer_two_count_match = timer_two_count_match;
  assign ev.timer_one_count_rollover = timer_one_count_rollover;
  // mode fields from the control register
  assign ev.ccp_mode = peripheral_flags_pkg::ccp_mode_t'(
    ctrl_ff[peripheral_flags_pkg::CTRL_CCP_LSB +: 2]);
  assign ev.ssp_mode = peripheral_flags_pkg::ssp_mode_t'(
    ctrl_ff[peripheral_flags_pkg::CTRL_SSP_LSB +: 2]);
  assign ev.multi_master = ctrl_ff[peripheral_flags_pkg::CTRL_MM_BIT];

  // bundle to the event qualifier
  flag_event_qualifier #(
    .HAS_PSP(HAS_PSP)
  ) u_qualifier (
    .pclk(pclk),
    .presetn(presetn),
    .ev(ev)
  );

  // receive and transmit bits follow the serial buffers directly
  always_comb begin
    flags_view = flags_ff;
    flags_view[peripheral_flags_pkg::BIT_RX] = rx_buffer_full;
    flags_view[peripheral_flags_pkg::BIT_TX] = tx_buffer_empty;
  end

  // bit 7 has no source and no storage without the parallel port
  always_comb begin
    flag_keep = peripheral_flags_pkg::FLAGS_WR_MASK;
    if (!HAS_PSP) begin
      flag_keep[peripheral_flags_pkg::BIT_PSP] = 1'b0;
    end
  end

  // flag register: a write stores the byte, a coincident event still sets
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_flags) begin
      nxt_flags = wbyte;
    end
    // writes to the level bits fall away through the keep mask
    nxt_flags = (nxt_flags | ev.set_vec) & flag_keep;
  end

  // flag storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= peripheral_flags_pkg::FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // control only changes on a write
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = wbyte[peripheral_flags_pkg::CTRL_W-1:0];
    end
  end

  // mask only changes on a write
  always_comb begin
    nxt_mask = mask_ff;
    if (wr_mask) begin
      nxt_mask = wbyte;
    end
  end

  // control and mask storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= peripheral_flags_pkg::CTRL_RST;
      mask_ff <= peripheral_flags_pkg::MASK_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
    end
  end

  // sticky event bits: a read clears only what that read returned
  always_comb begin
    nxt_event = event_ff;
    if (rd_event) begin
      nxt_event = event_ff & ~prdata_ff[7:0];
    end
    // a set in the same cycle as the clearing read survives
    nxt_event = nxt_event | ev.event_vec;
  end

  // irq follows the next status so it rises with the event bit
  always_comb begin
    nxt_irq = |(nxt_event & nxt_mask);
  end

  // event status and interrupt line storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_ff <= peripheral_flags_pkg::EVENT_RST;
      irq_ff <= 1'b0;
    end else begin
      event_ff <= nxt_event;
      irq_ff <= nxt_irq;
    end
  end

  assign pend_view = event_ff & mask_ff;

  // register read mux
  always_comb begin
    case (sel)
      REG_CTRL: rd_byte = 8'(ctrl_ff);
      REG_FLAGS: rd_byte = flags_view;
      REG_EVENT: rd_byte = event_ff;
      REG_MASK: rd_byte = mask_ff;
      REG_PEND: rd_byte = pend_view;
      default: rd_byte = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle, the access cycle answers
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (setup) begin
      nxt_prdata = {24'h000000, pwrite ? 8'h00 : rd_byte};
      nxt_pslverr = (sel == REG_NONE);
    end
  end

  // bus response storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign pready = access;
  assign prdata = prdata_ff;
  // unmapped addresses answer with pslverr in the access cycle
  assign pslverr = pslverr_ff & access;
  assign irq = irq_ff;
  assign peripheral_request_flags_one = flags_view;

endmodule : peripheral_interrupt_flags
`default_nettype wire

// File: flags_asserts.sv
// checker for the peripheral flag block, bound to its top ports
// assumes the parallel port is present and one pclk domain
`timescale 1ns/1ps
`default_nettype none
module flags_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [7:0] peripheral_request_flags_one,
  input wire logic psp_access_done,
  input wire logic adc_conv_done,
  input wire logic rx_buffer_full,
  input wire logic tx_buffer_empty,
  input wire logic timer_two_count_match,
  input wire logic timer_one_count_rollover
);
  logic [7:0] f;
  logic wr;
  assign f = peripheral_request_flags_one;
  assign wr = psel && penable && pwrite && pstrb[0] &&
    paddr == ADDR_W'(peripheral_flags_pkg::FLAGS_OFS);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a clearing write that meets a timer one rollover
  sequence roll_during_clear;
    wr && !pwdata[0] && timer_one_count_rollover;
  endsequence
  a_timer_one_count_sets_flag: assert property (timer_one_count_rollover |=> f[0])
    else $error("timer one flag missed");
  a_timer_two_count_sets_flag: assert property (timer_two_count_match |=> f[1])
    else $error("timer two flag missed");
  a_adc_sets_flag: assert property (adc_conv_done |=> f[6])
    else $error("conversion flag missed");
  a_psp_sets_flag: assert property (psp_access_done |=> f[7])
    else $error("parallel port flag missed");
  a_rx_level_shown: assert property (f[5] == rx_buffer_full)
    else $error("receive flag wrong");
  a_tx_level_shown: assert property (f[4] == tx_buffer_empty)
    else $error("transmit flag wrong");
  a_flags_stay_set: assert property (|($past(f) & 8'hCF & ~f) |-> $past(wr))
    else $error("flag fell without a write");
  a_set_beats_clear: assert property (roll_during_clear |=> f[0])
    else $error("clear beat a new event");
endmodule : flags_asserts
`default_nettype wire

// File: peripheral_model.sv
// far-side peripherals: one-cycle event pulses and buffer levels
// assumes pclk is the block clock
`timescale 1ns/1ps
`default_nettype none
module peripheral_model (
  input wire logic pclk,
  output logic [12:0] ev,
  output logic rx_full,
  output logic tx_empty,
  output logic idle
);
  initial begin
    ev = 13'h0000;
    rx_full = 1'b0;
    tx_empty = 1'b0;
    idle = 1'b0;
  end
  // one-cycle pulse, raised and dropped just after edges
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask : pulse
  task automatic levels(input logic r, input logic t, input logic d);
    @(posedge pclk);
    rx_full <= r;
    tx_empty <= t;
    idle <= d;
  endtask : levels
endmodule : peripheral_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench: apb register tests and peripheral event scenarios
// assumes package, design, model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int ADDR_W = 8;
  localparam logic [7:0] FL = peripheral_flags_pkg::FLAGS_OFS;
  localparam logic [7:0] CT = peripheral_flags_pkg::CTRL_OFS;
  localparam logic [7:0] EV = peripheral_flags_pkg::EVENT_OFS;
  localparam logic [7:0] MK = peripheral_flags_pkg::MASK_OFS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, irq, rx_full, tx_empty, idle, err;
  logic [7:0] flags;
  logic [12:0] ev;
  logic [31:0] rd;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  peripheral_model pm (.pclk(pclk), .ev(ev), .rx_full(rx_full),
    .tx_empty(tx_empty), .idle(idle));
  peripheral_interrupt_flags #(.ADDR_W(ADDR_W), .HAS_PSP(1'b1)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .peripheral_request_flags_one(flags), .psp_access_done(ev[11]),
    .adc_conv_done(ev[12]), .rx_buffer_full(rx_full),
    .tx_buffer_empty(tx_empty), .ssp_byte_done(ev[4]),
    .ssp_start_done(ev[5]), .ssp_stop_done(ev[6]),
    .ssp_restart_done(ev[7]), .ssp_ack_done(ev[8]),
    .bus_start_seen(ev[9]), .bus_stop_seen(ev[10]), .ssp_idle(idle),
    .ccp_capture(ev[2]), .ccp_match(ev[3]), .timer_two_count_match(ev[1]),
    .timer_one_count_rollover(ev[0]));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rc(FL, 32'h0);
    pm.levels(1'b1, 1'b1, 1'b0);
    apb(1'b1, FL, 32'h0);
    rc(FL, 32'h30);
    pm.levels(1'b0, 1'b0, 1'b1);
    apb(1'b1, FL, 32'hFF);
    rc(FL, 32'hCF);
    apb(1'b1, FL, 32'h0);
    rc(FL, 32'h0);
    // every event with all enables and modes off
    for (int i = 0; i < 13; i++) pm.pulse(i);
    rc(FL, 32'hC3);
    apb(1'b1, FL, 32'h0);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CT, 32'(m));
      for (int k = 2; k < 4; k++) begin
        pm.pulse(k);
        rc(FL, (m == k - 1) ? 32'h4 : 32'h0);
        apb(1'b1, FL, 32'h0);
      end
    end
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, CT, 32'(s * 4 + 16));
      for (int k = 4; k < 11; k++) begin
        pm.pulse(k);
        rc(FL, (s > 0 && (k == 4 || (s == 3 && k < 9) || (s > 1 && k > 8)))
          ? 32'h8 : 32'h0);
        apb(1'b1, FL, 32'h0);
      end
    end
    rc(CT, 32'h1C);
    pm.levels(1'b0, 1'b0, 1'b0);
    pm.pulse(9);
    rc(FL, 32'h0);
    fork
      apb(1'b1, FL, 32'h0);
      begin
        @(posedge pclk);
        pm.pulse(0);
      end
    join
    rc(FL, 32'h1);
    apb(1'b1, MK, 32'h0);
    rc(EV, 32'hFF);
    pm.pulse(1);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rc(FL, 32'h3);
    chk(32'(flags), 32'h3);
    apb(1'b1, MK, 32'h2);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rc(peripheral_flags_pkg::PEND_OFS, 32'h2);
    rc(EV, 32'h2);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rc(8'h40, 32'h0);
    chk(32'(err), 32'h1);
    give_verdict();
  end
endmodule : tb_top
bind peripheral_interrupt_flags flags_asserts #(.ADDR_W(ADDR_W)) chk_i (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .peripheral_request_flags_one(peripheral_request_flags_one),
  .psp_access_done(psp_access_done),
  .adc_conv_done(adc_conv_done),
  .rx_buffer_full(rx_buffer_full),
  .tx_buffer_empty(tx_buffer_empty),
  .timer_two_count_match(timer_two_count_match),
  .timer_one_count_rollover(timer_one_count_rollover)
);
`default_nettype wire
